/* inc/cct_pkg.sv */
// Shared constants for the charge/discharge time counter register bank.
// Assumes a single 250 MHz clock and a host command port already decoded into bytes.
package cct_pkg;

    // Register addresses, seven bits as carried in a command byte.
    localparam logic [6:0] ADDR_OFFSET     = 7'h73;
    localparam logic [6:0] ADDR_TEMP_CLEAR = 7'h74;
    localparam logic [6:0] ADDR_MODE       = 7'h75;
    localparam logic [6:0] ADDR_CTIME_LOW  = 7'h76;
    localparam logic [6:0] ADDR_CTIME_HIGH = 7'h77;
    localparam logic [6:0] ADDR_DTIME_LOW  = 7'h78;
    localparam logic [6:0] ADDR_DTIME_HIGH = 7'h79;

    // Command byte layout.
    localparam int CMD_WRITE_BIT = 7;

    // Mode register fields.
    localparam int MODE_OVR_BIT  = 7;
    localparam int MODE_CAL_BIT  = 6;
    localparam int MODE_STC_BIT  = 5;
    localparam int MODE_STD_BIT  = 4;
    localparam int WAKE_LSB      = 1;
    localparam int WAKE_W        = 3;
    localparam logic [2:0] WAKE_RESET = 3'h7;

    // Temperature/clear register fields.
    localparam int TEMP_LSB      = 5;
    localparam int TEMP_W        = 3;
    localparam int CLR_W         = 5;
    localparam int CLR_CTIME_BIT = 4;
    localparam int CLR_DTIME_BIT = 3;
    localparam int CLR_SELF_BIT  = 2;
    localparam int CLR_CHG_BIT   = 1;
    localparam int CLR_DSG_BIT   = 0;

    // Identity mapping of the sensed temperature code onto the reported field.
    localparam logic [23:0] TEMP_MAP_DFLT = 24'hFA_C688;

    // Sense path: signed microvolt samples; 3.84 mV wake reference.
    localparam int SENSE_W     = 19;
    localparam int WAKE_REF_UV = 3840;

    // Counter rates and clock.
    localparam int CNT_W          = 16;
    localparam longint HOUR_S         = 3600;
    localparam longint CLK_PERIOD_NS  = 4;
    localparam longint FAST_PER_HOUR  = 4096;
    localparam longint SLOW_PER_HOUR  = 16;
    localparam longint FAST_TICK_CYCLES_DFLT =
        (HOUR_S * 64'd1_000_000_000) / CLK_PERIOD_NS / FAST_PER_HOUR;
    localparam int SLOW_DIV_W = 8;   // FAST_PER_HOUR / SLOW_PER_HOUR = 256 ticks.

endpackage

/* inc/cct_cnt_if.sv */
// Carrier between the register bank and one time counter.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface cct_cnt_if;
    logic        enable;
    logic        tick;
    logic        slow_tick;
    logic        clear;
    logic [15:0] count;
    logic        slow_flag;

    modport counter (input enable, input tick, input slow_tick, input clear,
                     output count, output slow_flag);
    modport ctrl    (output enable, output tick, output slow_tick, output clear,
                     input count, input slow_flag);
endinterface

/* logic/cct_time_counter.sv */
// One 16-bit elapsed-time counter with rollover flag and slow-rate mode.
// Assumes tick and slow_tick are one-cycle enables from the shared prescaler.
`timescale 1ns/100ps
module cct_time_counter (
    input  wire logic     mclk_i,
    input  wire logic     rst_i,
    cct_cnt_if.counter    cnt
);
    import cct_pkg::*;

    logic [CNT_W-1:0] count_q;
    logic             flag_q;
    logic             advance;
    logic             wrap;

    // Once the flag is up the counter runs at the slow rate.
    assign advance = cnt.enable & (flag_q ? cnt.slow_tick : cnt.tick);
    assign wrap    = advance & (count_q == 16'hFFFF);

    // Clear beats a same-cycle rollover; the counter restarts from zero anyway.
    always_ff @(posedge mclk_i) begin
        if (rst_i || cnt.clear) begin
            count_q <= '0;
            flag_q  <= 1'b0;
        end else begin
            count_q <= count_q + 16'h0001 * CNT_W'(advance);
            flag_q  <= flag_q ^ wrap;
        end
    end

    assign cnt.count     = count_q;
    assign cnt.slow_flag = flag_q;

    property p_roll_toggle;
        @(posedge mclk_i) disable iff (rst_i)
        (wrap && !cnt.clear) |=> (flag_q != $past(flag_q)) && (count_q == 16'h0000);
    endproperty
    a_roll_toggle: assert property (p_roll_toggle)
        else $error("time counter rollover did not toggle slow flag");

    property p_hold;
        @(posedge mclk_i) disable iff (rst_i)
        (!cnt.enable && !cnt.clear) |=> $stable(count_q) && $stable(flag_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("time counter moved while disabled");

    property p_clear;
        @(posedge mclk_i) disable iff (rst_i)
        cnt.clear |=> (count_q == 16'h0000) && !flag_q;
    endproperty
    a_clear: assert property (p_clear)
        else $error("time counter clear did not zero count and flag");

endmodule // cct_time_counter

/* logic/cct_coulomb_regs.sv */
// Register bank for the charge/discharge time counters, mode, temperature and offset.
// Assumes the serial framing is decoded elsewhere into bytes on mclk_i, and the
// sense sample, temperature code and calibration result come from on-chip logic.
`timescale 1ns/100ps

module cct_coulomb_regs #(
    parameter int unsigned FAST_TICK_CYCLES = int'(cct_pkg::FAST_TICK_CYCLES_DFLT),
    parameter logic [23:0] TEMP_MAP         = cct_pkg::TEMP_MAP_DFLT
) (
    input  wire logic                              mclk_i,
    input  wire logic                              rst_i,
    input  wire logic                              byte_valid_i,
    input  wire logic [7:0]                        byte_i,
    output logic                                   rd_valid_o,
    output logic [7:0]                             rd_data_o,
    input  wire logic                              serial_line_i,
    input  wire logic signed [cct_pkg::SENSE_W-1:0] sense_uv_i,
    input  wire logic [cct_pkg::TEMP_W-1:0]        temp_code_i,
    input  wire logic                              cal_done_i,
    input  wire logic [7:0]                        cal_offset_i,
    output logic                                   cal_run_o,
    output logic                                   wake_o,
    output logic                                   wake_oe_o,
    output logic [2:0]                             clear_count_o
);
    import cct_pkg::*;

    localparam int EW = SENSE_W + 1;   // Width of sense plus offset.
    localparam int PW = EW + WAKE_W;   // Width of magnitude times threshold field.

    typedef enum logic { HOST_CMD, HOST_DATA } cct_host_t;
    typedef enum logic { CAL_IDLE, CAL_RUN }   cct_cal_t;

    // Command decoding shared by read and write paths.
    function automatic logic is_addr(input logic [6:0] a, input logic [6:0] target);
        return a == target;
    endfunction

    function automatic logic [TEMP_W-1:0] temp_lookup(input logic [TEMP_W-1:0] code);
        int idx;
        idx = 3 * int'(code);
        return TEMP_MAP[idx +: TEMP_W];
    endfunction

    cct_cnt_if ctime ();
    cct_cnt_if dtime ();

    // Registers.
    cct_host_t         host_q;
    cct_cal_t          cal_state_q;
    logic [6:0]        wr_addr_q;
    logic [7:0]        rd_data_q;
    logic              rd_valid_q;
    logic              ovr_q;
    logic              cal_q;
    logic [WAKE_W-1:0] wake_sel_q;
    logic [CLR_W-1:0]  clear_q;
    logic [7:0]        offset_q;
    logic [TEMP_W-1:0] temp_q;
    logic              line_meta_q;
    logic              line_q;
    logic              cal_run_q;
    logic              wake_oe_q;
    logic              wake_q;
    logic [31:0]       fast_cnt_q;
    logic [SLOW_DIV_W-1:0] slow_cnt_q;
    logic              tick_q;
    logic              slow_tick_q;

    // Next values and decoded strobes.
    cct_host_t         host_d;
    cct_cal_t          cal_state_d;
    logic              cmd_take;
    logic              cmd_read;
    logic              wr_en;
    logic              wr_offset;
    logic              wr_temp_clear;
    logic              wr_mode;
    logic              cal_ok;
    logic              ovr_d;
    logic              cal_d;
    logic [WAKE_W-1:0] wake_sel_d;
    logic [7:0]        offset_d;
    logic [CLR_W-1:0]  clear_d;
    logic [7:0]        rd_mux;
    logic [7:0]        mode_view;
    logic [7:0]        temp_clear_view;

    // Sense path.
    logic signed [EW-1:0] eff_sense;
    logic [EW-1:0]        eff_mag;
    logic [PW-1:0]        mag_x_sel;
    logic                 below_wake;
    logic                 start_ok;

    // Host command port: a command byte, then a data byte only for writes.
    assign cmd_take      = byte_valid_i & (host_q == HOST_CMD);
    assign cmd_read      = cmd_take & ~byte_i[CMD_WRITE_BIT];
    assign wr_en         = byte_valid_i & (host_q == HOST_DATA);
    assign wr_offset     = wr_en & is_addr(wr_addr_q, ADDR_OFFSET);
    assign wr_temp_clear = wr_en & is_addr(wr_addr_q, ADDR_TEMP_CLEAR);
    assign wr_mode       = wr_en & is_addr(wr_addr_q, ADDR_MODE);
    assign host_d        = (cmd_take & byte_i[CMD_WRITE_BIT]) ? HOST_DATA :
                           wr_en ? HOST_CMD : host_q;

    // Read views; bit 0 of the mode register is held at zero.
    assign mode_view = {ovr_q, cal_q, ctime.slow_flag, dtime.slow_flag,
                        wake_sel_q, 1'b0};
    assign temp_clear_view = {temp_q, clear_q};
    assign rd_mux =
        is_addr(byte_i[6:0], ADDR_OFFSET)     ? offset_q :
        is_addr(byte_i[6:0], ADDR_TEMP_CLEAR) ? temp_clear_view :
        is_addr(byte_i[6:0], ADDR_MODE)       ? mode_view :
        is_addr(byte_i[6:0], ADDR_CTIME_LOW)  ? ctime.count[7:0] :
        is_addr(byte_i[6:0], ADDR_CTIME_HIGH) ? ctime.count[15:8] :
        is_addr(byte_i[6:0], ADDR_DTIME_LOW)  ? dtime.count[7:0] :
        is_addr(byte_i[6:0], ADDR_DTIME_HIGH) ? dtime.count[15:8] : 8'h00;

    // Effective sense is the sample corrected by the stored offset.
    assign eff_sense  = EW'(sense_uv_i) + EW'($signed(offset_q));
    assign eff_mag    = eff_sense[EW-1] ? EW'(-eff_sense) : EW'(eff_sense);
    // Comparing magnitude times the field against 3.84 mV avoids a divider.
    assign mag_x_sel  = PW'(eff_mag) * PW'(wake_sel_q);
    assign below_wake = mag_x_sel < PW'(WAKE_REF_UV);
    assign start_ok   = below_wake & (ovr_q | ~line_q);

    // Calibration sequencer; loss of the start condition or of the request abandons the run.
    assign cal_ok      = (cal_state_q == CAL_RUN) & cal_q & start_ok & cal_done_i;
    always_comb begin
        cal_state_d = cal_state_q;
        case (cal_state_q)
            CAL_IDLE: if (cal_q && start_ok) begin
                cal_state_d = CAL_RUN;
            end
            CAL_RUN: if (!start_ok || !cal_q || cal_done_i) begin
                cal_state_d = CAL_IDLE;
            end
            default: cal_state_d = CAL_IDLE;
        endcase
    end

    // A host mode write in the completion cycle wins, so a fresh request is not lost; cal_ok beats an offset write.
    assign ovr_d      = wr_mode ? byte_i[MODE_OVR_BIT] : (ovr_q & ~cal_ok);
    assign cal_d      = wr_mode ? byte_i[MODE_CAL_BIT] : (cal_q & ~cal_ok);
    assign wake_sel_d = wr_mode ? byte_i[WAKE_LSB +: WAKE_W] : wake_sel_q;
    assign offset_d   = cal_ok ? cal_offset_i : wr_offset ? byte_i : offset_q;
    // Clear bits stand for one cycle, then read back as 0 to show completion.
    assign clear_d    = wr_temp_clear ? byte_i[CLR_W-1:0] : '0;

    // Counter hookup; each clear bit reaches only its own counter.
    assign ctime.enable    = ~eff_sense[EW-1] & (eff_sense != '0);
    assign dtime.enable    = eff_sense[EW-1];
    assign ctime.tick      = tick_q;
    assign dtime.tick      = tick_q;
    assign ctime.slow_tick = slow_tick_q;
    assign dtime.slow_tick = slow_tick_q;
    assign ctime.clear     = clear_q[CLR_CTIME_BIT];
    assign dtime.clear     = clear_q[CLR_DTIME_BIT];

    // Both time counters share one rollover-toggling counter design.
    cct_time_counter u_charge_time (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .cnt    (ctime.counter)
    );
    cct_time_counter u_discharge_time (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .cnt    (dtime.counter)
    );

    // Rate prescaler: fast tick 4096 per hour, slow tick every 256th fast tick.
    always_ff @(posedge mclk_i) begin
        if (rst_i || fast_cnt_q == FAST_TICK_CYCLES - 1) begin
            fast_cnt_q <= '0;
        end else begin
            fast_cnt_q <= fast_cnt_q + 32'h0000_0001;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            slow_cnt_q  <= '0;
            tick_q      <= 1'b0;
            slow_tick_q <= 1'b0;
        end else begin
            tick_q      <= (fast_cnt_q == FAST_TICK_CYCLES - 1);
            slow_cnt_q  <= slow_cnt_q + SLOW_DIV_W'(tick_q);
            slow_tick_q <= tick_q & (slow_cnt_q == '1);
        end
    end

    // Serial line level arrives from a pin and is synchronised before use.
    always_ff @(posedge mclk_i) begin
        line_meta_q <= serial_line_i;
        line_q      <= line_meta_q;
    end

    // Host port and read return.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            host_q     <= HOST_CMD;
            wr_addr_q  <= '0;
            rd_valid_q <= 1'b0;
            rd_data_q  <= '0;
        end else begin
            host_q     <= host_d;
            wr_addr_q  <= cmd_take ? byte_i[6:0] : wr_addr_q;
            rd_valid_q <= cmd_read;
            rd_data_q  <= cmd_read ? rd_mux : rd_data_q;
        end
    end

    // Mode, offset and clear registers; threshold bits come up as ones.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ovr_q      <= 1'b0;
            cal_q      <= 1'b0;
            wake_sel_q <= WAKE_RESET;
            offset_q   <= '0;
            clear_q    <= '0;
        end else begin
            ovr_q      <= ovr_d;
            cal_q      <= cal_d;
            wake_sel_q <= wake_sel_d;
            offset_q   <= offset_d;
            clear_q    <= clear_d;
        end
    end

    // Status flops driving pins; the wake pin only ever pulls low.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cal_state_q <= CAL_IDLE;
            cal_run_q   <= 1'b0;
            wake_oe_q   <= 1'b0;
            wake_q      <= 1'b0;
            temp_q      <= '0;
        end else begin
            cal_state_q <= cal_state_d;
            cal_run_q   <= (cal_state_d == CAL_RUN);
            wake_oe_q   <= ~below_wake;
            wake_q      <= 1'b0;
            temp_q      <= temp_lookup(temp_code_i);
        end
    end

    assign rd_valid_o    = rd_valid_q;
    assign rd_data_o     = rd_data_q;
    assign cal_run_o     = cal_run_q;
    assign wake_o        = wake_q;
    assign wake_oe_o     = wake_oe_q;
    assign clear_count_o = clear_q[CLR_SELF_BIT:CLR_DSG_BIT];

    property p_wake_reset;
        @(posedge mclk_i) disable iff (rst_i)
        $past(rst_i) |-> (wake_sel_q == WAKE_RESET) && !ovr_q && !cal_q;
    endproperty
    a_wake_reset: assert property (p_wake_reset)
        else $error("wake threshold bits not ones after reset");

    property p_wake_pin;
        @(posedge mclk_i) disable iff (rst_i)
        below_wake ##1 below_wake |-> !wake_oe_o && !wake_o;
    endproperty
    a_wake_pin: assert property (p_wake_pin)
        else $error("wake pin driven while sense below threshold");

    property p_cal_done;
        @(posedge mclk_i) disable iff (rst_i)
        (cal_ok && !wr_mode && !wr_offset) |=>
            !ovr_q && !cal_q && (offset_q == $past(cal_offset_i)) ##1 !cal_run_o;
    endproperty
    a_cal_done: assert property (p_cal_done)
        else $error("valid calibration did not load offset and clear bits");

    property p_cal_abort;
        @(posedge mclk_i) disable iff (rst_i)
        (cal_state_q == CAL_RUN && !start_ok && !wr_mode) |=>
            !cal_run_o && (cal_q == $past(cal_q));
    endproperty
    a_cal_abort: assert property (p_cal_abort)
        else $error("calibration not abandoned when start condition lost");

    property p_cal_gate;
        @(posedge mclk_i) disable iff (rst_i)
        (cal_state_q == CAL_IDLE && !ovr_q && line_q) |=> !cal_run_o;
    endproperty
    a_cal_gate: assert property (p_cal_gate)
        else $error("calibration started with line high and no override");

    property p_clear_bit;
        @(posedge mclk_i) disable iff (rst_i)
        (wr_temp_clear && byte_i[CLR_CTIME_BIT]) |=>
            clear_q[CLR_CTIME_BIT] ##1 !clear_q[CLR_CTIME_BIT] && (ctime.count == 16'h0000);
    endproperty
    a_clear_bit: assert property (p_clear_bit)
        else $error("charge time clear did not zero counter and self-return");

    property p_read_ack;
        @(posedge mclk_i) disable iff (rst_i)
        (cmd_read && is_addr(byte_i[6:0], ADDR_MODE)) |=>
            rd_valid_o && (rd_data_o[0] == 1'b0) ##1 (rd_valid_o == $past(cmd_read));
    endproperty
    a_read_ack: assert property (p_read_ack)
        else $error("read command not answered in one cycle");

endmodule // cct_coulomb_regs

/* test/cct_host_model.sv */
// Host controller model: sends decoded command and data bytes and drives the serial line.
// Assumes the register bank takes one byte per edge while byte_valid_i is high.
`timescale 1ns/100ps
module cct_host_model (
    input  wire logic       mclk_i,
    input  wire logic       rd_valid_i,
    input  wire logic [7:0] rd_data_i,
    output logic            byte_valid_o,
    output logic [7:0]      byte_o,
    output logic            line_o
);
    // The line idles high through its pull-up, so that is the level at time zero.
    initial begin
        byte_valid_o = 1'b0;
        byte_o       = 8'h00;
        line_o       = 1'b1;
    end

    // Command then data on back-to-back edges; a released byte bus shows no stale value.
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        byte_valid_o = 1'b1;
        byte_o       = {1'b1, a};
        @(posedge mclk_i);
        #1 byte_o = d;
        @(posedge mclk_i);
        #1 byte_valid_o = 1'b0;
        byte_o = ~d;
        @(posedge mclk_i);
        #1;
    endtask

    // A read waits a bounded time for the answer pulse; no answer reads as unknown.
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        int n;
        n            = 0;
        byte_valid_o = 1'b1;
        byte_o       = {1'b0, a};
        @(posedge mclk_i);
        #1 byte_valid_o = 1'b0;
        byte_o = ~byte_o;
        // The answer pulse already stands right after the command edge.
        while (rd_valid_i !== 1'b1 && n < 8) begin
            @(posedge mclk_i);
            #1 n++;
        end
        d = (rd_valid_i === 1'b1) ? rd_data_i : 8'hxx;
        // Let an edge pass so a following request never lands in this time step.
        @(posedge mclk_i);
        #1;
    endtask

    task automatic set_line(input logic l);
        line_o = l;
    endtask
endmodule // cct_host_model

/* test/cct_coulomb_regs_tb.sv */
// Self-checking bench for the time counter register bank, driven by the host model.
// Assumes a shortened fast tick; the calibration engine is played by the bench.
`timescale 1ns/100ps
module cct_coulomb_regs_tb;
    import cct_pkg::*;
    localparam int unsigned FT       = 20;
    localparam logic [7:0]  MODE_RST = {4'h0, WAKE_RESET, 1'b0};
    logic                      mclk_i       = 1'b0;
    logic                      rst_i        = 1'b1;
    logic                      cal_done_i   = 1'b0;
    logic [7:0]                cal_offset_i = 8'h00;
    logic signed [SENSE_W-1:0] sense_uv_i   = '0;
    logic [TEMP_W-1:0]         temp_code_i  = '0;
    logic                      byte_valid_i, rd_valid_o, line, cal_run_o, wake_o, wake_oe_o;
    logic [7:0]                byte_i, rd_data_o, v, c;
    logic [2:0]                clear_count_o;
    logic signed [SENSE_W-1:0] sense2_uv    = '0;
    logic [7:0]                rd2;
    logic                      clr_seen     = 1'b0;
    int                        fails        = 0;
    int                        comparisons  = 0;

    // Free-running 250 MHz clock, and a latch of the count-clear pulses.
    always #2 mclk_i = ~mclk_i;
    always @(posedge mclk_i) if (clear_count_o === 3'b111) clr_seen <= 1'b1;

    cct_coulomb_regs #(.FAST_TICK_CYCLES(FT)) dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .byte_valid_i(byte_valid_i), .byte_i(byte_i),
        .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .serial_line_i(line),
        .sense_uv_i(sense_uv_i), .temp_code_i(temp_code_i), .cal_done_i(cal_done_i),
        .cal_offset_i(cal_offset_i), .cal_run_o(cal_run_o), .wake_o(wake_o),
        .wake_oe_o(wake_oe_o), .clear_count_o(clear_count_o));
    cct_host_model host (.mclk_i(mclk_i), .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o),
        .byte_valid_o(byte_valid_i), .byte_o(byte_i), .line_o(line));
    // A second bank ticking every cycle, so that a counter wrap fits in the run.
    // It shares the host bus; its read data is watched directly after each read in t_roll.
    cct_coulomb_regs #(.FAST_TICK_CYCLES(1)) dut_fast (
        .mclk_i(mclk_i), .rst_i(rst_i), .byte_valid_i(byte_valid_i), .byte_i(byte_i),
        .rd_valid_o(), .rd_data_o(rd2), .serial_line_i(line),
        .sense_uv_i(sense2_uv), .temp_code_i(temp_code_i), .cal_done_i(cal_done_i),
        .cal_offset_i(cal_offset_i), .cal_run_o(), .wake_o(),
        .wake_oe_o(), .clear_count_o());

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
        host.rd(a, v);
        check(v, exp);
    endtask

    task automatic t_reset;
        rchk(ADDR_MODE, MODE_RST);
        rchk(ADDR_OFFSET, 8'h00);
        rchk(7'h10, 8'h00);
        $display("test reset done");
    endtask

    // Every temperature code is mapped through the table into bits 7 to 5.
    task automatic t_temp;
        for (int i = 0; i < 8; i++) begin
            temp_code_i = i[2:0];
            cyc(2);
            rchk(ADDR_TEMP_CLEAR, {TEMP_MAP_DFLT[3*i+:3], 5'h00});
        end
        $display("test temperature done");
    endtask

    // Threshold is 3840 uV over the field; equal magnitude counts as above.
    task automatic t_wake;
        sense_uv_i = 19'sh0EFF;
        cyc(3);
        check({7'h0, wake_oe_o}, 8'h01);
        host.wr(ADDR_MODE, 8'h02);
        cyc(3);
        check({7'h0, wake_oe_o}, 8'h00);
        sense_uv_i = 19'sh0F00;
        cyc(3);
        check({7'h0, wake_oe_o}, 8'h01);
        sense_uv_i = -19'sh0F00;
        cyc(3);
        check({6'h0, wake_oe_o, wake_o}, 8'h02);
        sense_uv_i = '0;
        cyc(3);
        check({7'h0, wake_oe_o}, 8'h00);
        host.wr(ADDR_MODE, MODE_RST);
        $display("test wake done");
    endtask

    // Charge then discharge time; each counter holds while the polarity is wrong.
    task automatic t_count;
        host.wr(ADDR_TEMP_CLEAR, 8'h18);
        sense_uv_i = 19'sh03E8;
        cyc(40 * FT);
        sense_uv_i = '0;
        host.rd(ADDR_CTIME_LOW, c);
        check({7'h0, c >= 8'd39 && c <= 8'd41}, 8'h01);
        rchk(ADDR_DTIME_LOW, 8'h00);
        sense_uv_i = -19'sh03E8;
        cyc(20 * FT);
        sense_uv_i = '0;
        host.rd(ADDR_DTIME_LOW, v);
        check({7'h0, v >= 8'd19 && v <= 8'd21}, 8'h01);
        rchk(ADDR_CTIME_LOW, c);
        host.wr(ADDR_TEMP_CLEAR, 8'h10);
        rchk(ADDR_CTIME_LOW, 8'h00);
        host.rd(ADDR_DTIME_LOW, c);
        check({7'h0, c >= 8'd19 && c <= 8'd21}, 8'h01);
        rchk(ADDR_TEMP_CLEAR, {TEMP_MAP_DFLT[21+:3], 5'h00});
        host.wr(ADDR_TEMP_CLEAR, 8'h08);
        rchk(ADDR_DTIME_LOW, 8'h00);
        host.wr(ADDR_TEMP_CLEAR, 8'h07);
        cyc(2);
        check({7'h0, clr_seen}, 8'h01);
        host.wr(ADDR_CTIME_LOW, 8'h55);
        rchk(ADDR_CTIME_LOW, 8'h00);
        host.wr(ADDR_MODE, 8'h3E);
        rchk(ADDR_MODE, MODE_RST);
        host.wr(ADDR_OFFSET, 8'h7F);
        rchk(ADDR_OFFSET, 8'h7F);
        $display("test counters done");
    endtask

    task automatic cal_finish(input logic [7:0] off);
        cal_offset_i = off;
        cal_done_i   = 1'b1;
        cyc(1);
        cal_done_i = 1'b0;
        cyc(2);
        rchk(ADDR_OFFSET, off);
        rchk(ADDR_MODE, MODE_RST);
    endtask

    // Line high blocks or abandons a run unless the override bit is set.
    task automatic t_cal;
        host.wr(ADDR_MODE, 8'h4E);
        cyc(10);
        check({7'h0, cal_run_o}, 8'h00);
        host.set_line(1'b0);
        cyc(10);
        check({7'h0, cal_run_o}, 8'h01);
        cal_finish(8'hF0);
        host.wr(ADDR_MODE, 8'h4E);
        cyc(10);
        host.set_line(1'b1);
        cyc(6);
        check({7'h0, cal_run_o}, 8'h00);
        rchk(ADDR_MODE, 8'h4E);
        host.wr(ADDR_MODE, 8'hCE);
        cyc(10);
        check({7'h0, cal_run_o}, 8'h01);
        cal_finish(8'h05);
        $display("test calibration done");
    endtask

    // The fast bank wraps its discharge counter once, then may only crawl at the slow
    // rate: 512 cycles give two slow ticks, where the fast rate would give 512 counts.
    task automatic t_roll;
        host.wr(ADDR_TEMP_CLEAR, 8'h18);
        sense2_uv = -19'sh03E8;
        cyc(65536 + 512);
        sense2_uv = '0;
        host.rd(ADDR_MODE, v);
        check({6'h0, rd2[5:4]}, 8'h01);
        host.rd(ADDR_DTIME_HIGH, v);
        check(rd2, 8'h00);
        host.rd(ADDR_DTIME_LOW, v);
        check({7'h0, rd2 >= 8'd1 && rd2 <= 8'd3}, 8'h01);
        host.wr(ADDR_TEMP_CLEAR, 8'h08);
        host.rd(ADDR_MODE, v);
        check({6'h0, rd2[5:4]}, 8'h00);
        $display("test rollover done");
    endtask

    task automatic print_verdict;
        $display("Counts: comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence after 16 reset cycles; the wrap test dominates at about 66k cycles,
    // so the watchdog sits at 75k cycles.
    initial begin
        repeat (16) @(posedge mclk_i);
        #1 rst_i = 1'b0;
        t_reset();
        t_temp();
        t_wake();
        t_count();
        t_cal();
        t_roll();
        print_verdict();
    end
    initial begin
        #300000;
        fails++;
        print_verdict();
    end
endmodule // cct_coulomb_regs_tb
